// ==== verilog/mcu_irq_regs.svh ====
// Register offsets, field positions and reset values of the interrupt controller
`ifndef MCU_IRQ_REGS_SVH
`define MCU_IRQ_REGS_SVH

// APB byte addresses
`define IRQ_CTRL_OFS    8'h00
`define IRQ_OPT_OFS     8'h04
`define IRQ_PFLAG1_OFS  8'h08
`define IRQ_PEN1_OFS    8'h0c
`define IRQ_STAT_OFS    8'h10
`define IRQ_MASK_OFS    8'h14
`define IRQ_STATE_OFS   8'h18

// main_irq_control_reg fields
`define CTL_GLB_EN 7
`define CTL_GRP_EN 6
`define CTL_TOE   5
`define CTL_EXE   4
`define CTL_PCE   3
`define CTL_TOF   2
`define CTL_EXF   1
`define CTL_PCF   0
`define CTL_RST   8'h00

// Option register: edge select only
`define OPT_EDGE  0
`define OPT_RST   8'h01

// Peripheral flag and enable registers
`define PER_W     4
`define PER_RST   4'h0

// Sticky event status
`define STAT_VEC  0
`define STAT_WAKE 1
`define STAT_RET  2
`define STAT_W    3
`define STAT_RST  3'h0

// Core facing constants
`define PC_W        13
`define VECTOR_ADDR 13'h0004
`define TMR_TOP     8'hff
`define TMR_ZERO    8'h00
`define STACK_DEPTH 8
`define STACK_AW    3

`endif

// ==== verilog/mcu_irq_pkg.sv ====
// Types shared by the interrupt controller modules
package mcu_irq_pkg;

  typedef logic [12:0] pc_type;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_WAKE_GAP
  } wake_state_type;

endpackage

// ==== verilog/irq_stack_if.sv ====
// Push and pop link between the controller and its return-address stack
`timescale 1ns/1ps
interface irq_stack_if;
  logic                 push;
  logic                 pop;
  mcu_irq_pkg::pc_type  push_pc;
  mcu_irq_pkg::pc_type  top_pc;
  logic [2:0]           depth;

  modport ctrl  (output push, output pop, output push_pc, input top_pc, input depth);
  modport store (input push, input pop, input push_pc, output top_pc, output depth);
endinterface

// ==== verilog/irq_return_stack.sv ====
// Circular hardware stack of return addresses
`timescale 1ns/1ps
`include "mcu_irq_regs.svh"
module irq_return_stack (
  input  wire logic   core_clk_i,
  input  wire logic   resetn_i,
  irq_stack_if.store  stk
);

  mcu_irq_pkg::pc_type mem [`STACK_DEPTH];
  logic [`STACK_AW-1:0] ptr_q;
  logic [`STACK_AW-1:0] ptr_d;
  logic [`STACK_AW-1:0] cnt_q;

  // Wraps like the core's stack: a ninth push overwrites the oldest entry
  always_comb begin
    ptr_d = ptr_q;
    if (stk.push) begin
      ptr_d = ptr_q + 3'h1;
    end else if (stk.pop) begin
      ptr_d = ptr_q - 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_q <= 3'h0;
      cnt_q <= 3'h0;
    end else begin
      ptr_q <= ptr_d;
      if (stk.push && cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1;
      end else if (stk.pop && !stk.push && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (stk.push) begin
      mem[ptr_q] <= stk.push_pc;
    end
  end

  assign stk.top_pc = mem[ptr_q - 3'h1];
  assign stk.depth  = cnt_q;

endmodule

// ==== verilog/mcu_irq_ctrl.sv ====
// Interrupt controller of a small microcontroller core with APB register access
//
// Functional notes
// - Seven sources, each flag plus enable
// - Flags set regardless of enables
// - Global enable gates every vector request, not irq_o
// - Pending enabled flag vectors at once
// - Reset and vectoring clear global enable
// - Return from handler sets global enable
// - Push return address, jump to 0004h
// - Peripheral flags gated by group enable
// - Pin events reach vector in 3-4 cycles
// - Pin edge chosen by edge select
// - Valid pin edge sets pin flag
// - Pin enable zero blocks pin request
// - Pin event wakes sleep if enabled
// - Timer FFh to 00h sets overflow flag
// - Port bits 7:4 change sets flag
// - Only return address saved by hardware
// - Wake ignores global enable, one instruction first
`timescale 1ns/1ps
`include "mcu_irq_regs.svh"
module mcu_irq_ctrl (
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Event sources
  input  wire logic                ext_irq_pin_i,
  input  wire logic [7:4]          second_io_port_i,
  input  wire logic [7:0]          timer_zero_count_i,
  input  wire logic [`PER_W-1:0]   periph_event_i,
  // Core sequencer
  input  wire logic                sleep_i,
  input  wire logic                return_from_handler_i,
  input  wire mcu_irq_pkg::pc_type return_pc_i,
  output logic                     irq_req_o,
  output logic                     vector_o,
  output logic                     wake_o,
  output logic                     pc_load_o,
  output mcu_irq_pkg::pc_type      pc_o,
  // Interrupt to system
  output logic                     irq_o
);

  irq_stack_if stk ();

  irq_return_stack u_stack (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .stk        (stk)
  );

  logic [7:0]          ctrl_q;
  logic [7:0]          ctrl_d;
  logic [7:0]          opt_q;
  logic [`PER_W-1:0]   pflag_q;
  logic [`PER_W-1:0]   pflag_d;
  logic [`PER_W-1:0]   pen_q;
  logic [`STAT_W-1:0]  stat_q;
  logic [`STAT_W-1:0]  stat_d;
  logic [`STAT_W-1:0]  mask_q;
  logic                ext_s1_q;
  logic                ext_s2_q;
  logic                ext_prev_q;
  logic [7:4]          port_s1_q;
  logic [7:4]          port_s2_q;
  logic [7:4]          port_prev_q;
  logic [7:0]          tmr_prev_q;
  mcu_irq_pkg::wake_state_type wstate_q;
  logic                acc_c;
  logic                wr_c;
  logic                rd_c;
  logic                ext_edge_c;
  logic                port_chg_c;
  logic                tmr_roll_c;
  logic                pend_c;
  logic                req_c;
  logic                fire_c;
  logic                wake_c;
  logic                hit_c;
  logic [31:0]         rdata_c;

  // APB: one wait state, all effects at the completing edge
  assign acc_c = psel_i && penable_i && pready_o;
  assign wr_c  = acc_c && pwrite_i;
  assign rd_c  = acc_c && !pwrite_i;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
    end
  end

  always_comb begin
    hit_c   = 1'b1;
    rdata_c = 32'h0000_0000;
    case (paddr_i)
      `IRQ_CTRL_OFS:   rdata_c[7:0] = ctrl_q;
      `IRQ_OPT_OFS:    rdata_c[7:0] = opt_q;
      `IRQ_PFLAG1_OFS: rdata_c[`PER_W-1:0] = pflag_q;
      `IRQ_PEN1_OFS:   rdata_c[`PER_W-1:0] = pen_q;
      `IRQ_STAT_OFS:   rdata_c[`STAT_W-1:0] = stat_q;
      `IRQ_MASK_OFS:   rdata_c[`STAT_W-1:0] = mask_q;
      `IRQ_STATE_OFS:  rdata_c[4:0] = {stk.depth, wstate_q == mcu_irq_pkg::ST_WAKE_GAP, sleep_i};
      default:         hit_c = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_c;
      pslverr_o <= !hit_c;
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // Pins are asynchronous: two flops before any logic
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_s1_q    <= 1'b0;
      ext_s2_q    <= 1'b0;
      ext_prev_q  <= 1'b0;
      port_s1_q   <= 4'h0;
      port_s2_q   <= 4'h0;
      port_prev_q <= 4'h0;
      tmr_prev_q  <= `TMR_ZERO;
    end else begin
      ext_s1_q    <= ext_irq_pin_i;
      ext_s2_q    <= ext_s1_q;
      ext_prev_q  <= ext_s2_q;
      port_s1_q   <= second_io_port_i;
      port_s2_q   <= port_s1_q;
      port_prev_q <= port_s2_q;
      tmr_prev_q  <= timer_zero_count_i;
    end
  end

  assign ext_edge_c = opt_q[`OPT_EDGE] ? (ext_s2_q && !ext_prev_q)
                                       : (!ext_s2_q && ext_prev_q);
  assign port_chg_c = port_s2_q != port_prev_q;
  assign tmr_roll_c = tmr_prev_q == `TMR_TOP && timer_zero_count_i == `TMR_ZERO;

  // Request forming
  always_comb begin
    pend_c = (ctrl_q[`CTL_TOF] && ctrl_q[`CTL_TOE])
          || (ctrl_q[`CTL_EXF] && ctrl_q[`CTL_EXE])
          || (ctrl_q[`CTL_PCF] && ctrl_q[`CTL_PCE])
          || (ctrl_q[`CTL_GRP_EN] && |(pflag_q & pen_q));
  end

  assign req_c  = ctrl_q[`CTL_GLB_EN] && pend_c;
  // A return in flight wins; the vector is retried once it has landed
  assign fire_c = req_c && !sleep_i && !return_from_handler_i
               && wstate_q == mcu_irq_pkg::ST_RUN;
  assign wake_c = sleep_i && pend_c && wstate_q == mcu_irq_pkg::ST_RUN;

  // Main control register; hardware sets beat software clears
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_c && paddr_i == `IRQ_CTRL_OFS) begin
      ctrl_d = pwdata_i[7:0];
    end
    if (ext_edge_c) begin
      ctrl_d[`CTL_EXF] = 1'b1;
    end
    if (tmr_roll_c) begin
      ctrl_d[`CTL_TOF] = 1'b1;
    end
    if (port_chg_c) begin
      ctrl_d[`CTL_PCF] = 1'b1;
    end
    if (return_from_handler_i) begin
      ctrl_d[`CTL_GLB_EN] = 1'b1;
    end else if (fire_c) begin
      ctrl_d[`CTL_GLB_EN] = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `CTL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opt_q <= `OPT_RST;
    end else if (wr_c && paddr_i == `IRQ_OPT_OFS) begin
      opt_q <= pwdata_i[7:0];
    end
  end

  // Peripheral flags and enables
  always_comb begin
    pflag_d = pflag_q;
    if (wr_c && paddr_i == `IRQ_PFLAG1_OFS) begin
      pflag_d = pwdata_i[`PER_W-1:0];
    end
    pflag_d = pflag_d | periph_event_i;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pflag_q <= `PER_RST;
      pen_q   <= `PER_RST;
    end else begin
      pflag_q <= pflag_d;
      if (wr_c && paddr_i == `IRQ_PEN1_OFS) begin
        pen_q <= pwdata_i[`PER_W-1:0];
      end
    end
  end

  // Wake: core runs one instruction before the vector may fire
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wstate_q <= mcu_irq_pkg::ST_RUN;
      wake_o   <= 1'b0;
    end else begin
      wake_o <= wake_c;
      case (wstate_q)
        mcu_irq_pkg::ST_RUN: begin
          if (wake_c) begin
            wstate_q <= mcu_irq_pkg::ST_WAKE_GAP;
          end
        end
        mcu_irq_pkg::ST_WAKE_GAP: begin
          wstate_q <= mcu_irq_pkg::ST_RUN;
        end
        default: wstate_q <= mcu_irq_pkg::ST_RUN;
      endcase
    end
  end

  // Stack and program counter; only the return address is kept
  assign stk.push    = fire_c;
  assign stk.push_pc = return_pc_i;
  assign stk.pop     = return_from_handler_i;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_o  <= 1'b0;
      pc_load_o <= 1'b0;
      pc_o      <= `VECTOR_ADDR;
      irq_req_o <= 1'b0;
    end else begin
      vector_o  <= fire_c;
      pc_load_o <= fire_c || return_from_handler_i;
      irq_req_o <= req_c;
      if (fire_c) begin
        pc_o <= `VECTOR_ADDR;
      end else if (return_from_handler_i) begin
        pc_o <= stk.top_pc;
      end
    end
  end

  // Sticky event status, cleared by reading; a new event beats the clear
  always_comb begin
    stat_d = stat_q;
    // Clear only what the read returned; an event after the data was taken survives
    if (rd_c && paddr_i == `IRQ_STAT_OFS) begin
      stat_d = stat_q & ~prdata_o[`STAT_W-1:0];
    end
    stat_d[`STAT_VEC]  = stat_d[`STAT_VEC]  | fire_c;
    stat_d[`STAT_WAKE] = stat_d[`STAT_WAKE] | wake_c;
    stat_d[`STAT_RET]  = stat_d[`STAT_RET]  | return_from_handler_i;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= `STAT_RST;
      mask_q <= `STAT_RST;
      irq_o  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_o  <= |(stat_d & mask_q);
      if (wr_c && paddr_i == `IRQ_MASK_OFS) begin
        mask_q <= pwdata_i[`STAT_W-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_VEC_CLEARS_EN: assert property (vector_o |-> !ctrl_q[`CTL_GLB_EN])
    else $error("global enable still set after vector");

  AST_VEC_CAUSE: assert property (vector_o |-> $past(ctrl_q[`CTL_GLB_EN] && pend_c))
    else $error("vector without enabled pending request");

  AST_VEC_PC: assert property (vector_o |-> pc_load_o && pc_o == `VECTOR_ADDR)
    else $error("vector did not load fixed address");

  AST_PEND_FIRES: assert property (req_c && !sleep_i && !return_from_handler_i
      && wstate_q == mcu_irq_pkg::ST_RUN |=> vector_o)
    else $error("enabled request not vectored");

  AST_EXT_LATENCY: assert property (ext_edge_c && ctrl_q[`CTL_EXE] && ctrl_q[`CTL_GLB_EN]
      ##1 ctrl_q[`CTL_GLB_EN] && ctrl_q[`CTL_EXE] && !sleep_i && !return_from_handler_i
      && wstate_q == mcu_irq_pkg::ST_RUN |=> vector_o)
    else $error("pin event latency exceeded");

  AST_EXT_FLAG: assert property (ext_edge_c |=> ctrl_q[`CTL_EXF])
    else $error("pin edge did not set flag");

  AST_TMR_FLAG: assert property (tmr_prev_q == `TMR_TOP && timer_zero_count_i == `TMR_ZERO
      |=> ctrl_q[`CTL_TOF])
    else $error("timer roll-over lost");

  AST_PORT_FLAG: assert property (port_s2_q != port_prev_q |=> ctrl_q[`CTL_PCF])
    else $error("port change lost");

  AST_RET_EN: assert property (return_from_handler_i |=> ctrl_q[`CTL_GLB_EN] && pc_load_o)
    else $error("return did not re-enable");

  AST_EN_OFF: assert property (!ctrl_q[`CTL_GLB_EN] |=> !vector_o)
    else $error("vector while globally disabled");

  AST_WAKE_GAP: assert property (wake_o |-> !vector_o ##1 !vector_o)
    else $error("vector before post-sleep instruction");

  AST_WAKE: assert property (sleep_i && pend_c && wstate_q == mcu_irq_pkg::ST_RUN |=> wake_o)
    else $error("enabled source did not wake");

  COV_VECTOR: cover property (vector_o);
  COV_WAKE_THEN_VEC: cover property (wake_o ##[1:8] vector_o);
  COV_RETURN: cover property (vector_o ##[1:50] return_from_handler_i);
  COV_STAT_IRQ: cover property (irq_o ##1 rd_c);

endmodule

// ==== sim/core_seq_model.sv ====
// Behavioural core sequencer facing the interrupt controller
`timescale 1ns/1ps
module core_seq_model (
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                sleep_i,
  input  wire logic                ret_req_i,
  input  wire logic                vector_i,
  input  wire logic                pc_load_i,
  input  wire mcu_irq_pkg::pc_type pc_i,
  output logic                     return_from_handler_o,
  output mcu_irq_pkg::pc_type      return_pc_o
);
  logic in_isr_q;

  // Program counter frozen while asleep
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      return_pc_o <= 13'h0100;
    end else if (pc_load_i) begin
      return_pc_o <= pc_i;
    end else if (!sleep_i) begin
      return_pc_o <= return_pc_o + 13'h0001;
    end
  end

  // Return only from inside a handler, after the bench cleared its flags
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_isr_q              <= 1'b0;
      return_from_handler_o <= 1'b0;
    end else begin
      in_isr_q              <= vector_i | (in_isr_q & ~return_from_handler_o);
      return_from_handler_o <= ret_req_i & in_isr_q & ~return_from_handler_o;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "mcu_irq_regs.svh"
module testbench;
  logic                core_clk_i = 0;
  logic                resetn_i   = 0;
  logic                psel = 0, penable = 0, pwrite = 0, pin = 0, sleep = 0, ret_req = 0;
  logic [7:0]          paddr = 8'h00, tcnt = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata, rd;
  logic [7:4]          port = 4'h0;
  logic [3:0]          pev = 4'h0;
  logic                pready, pslverr, ret, irq_req, vector, wake, pc_load, irq, err;
  mcu_irq_pkg::pc_type rpc, pc, last_pc, push_exp, rpc_prev;
  int                  cyc = 0, vec_n = 0, vec_cyc = 0, wake_n = 0, ret_n = 0, t0, v0, w0;
  int                  n_mismatch = 0, cmp_count = 0;

  always #10 core_clk_i = ~core_clk_i;

  mcu_irq_ctrl dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ext_irq_pin_i(pin), .second_io_port_i(port), .timer_zero_count_i(tcnt),
    .periph_event_i(pev), .sleep_i(sleep), .return_from_handler_i(ret), .return_pc_i(rpc),
    .irq_req_o(irq_req), .vector_o(vector), .wake_o(wake), .pc_load_o(pc_load), .pc_o(pc), .irq_o(irq));

  core_seq_model core_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .sleep_i(sleep), .ret_req_i(ret_req),
    .vector_i(vector), .pc_load_i(pc_load), .pc_i(pc), .return_from_handler_o(ret), .return_pc_o(rpc));

  // Pushed address is the core pc seen at the edge that raised the vector
  always @(posedge core_clk_i) begin
    cyc      <= cyc + 1;
    rpc_prev <= rpc;
    if (vector === 1'b1) begin
      vec_n    <= vec_n + 1;
      vec_cyc  <= cyc;
      push_exp <= rpc_prev;
    end
    if (wake === 1'b1) wake_n <= wake_n + 1;
    if (pc_load === 1'b1) last_pc <= pc;
    if (pc_load === 1'b1 && vector !== 1'b1) ret_n <= ret_n + 1;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(32'(pready), 32'h1, "apb answer");
    rd  = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, e, what);
  endtask

  task pin_set(input logic v);
    @(posedge core_clk_i);
    pin <= v;
    t0 = cyc;
    repeat (6) @(posedge core_clk_i);
  endtask

  task wait_vec(input int base);
    int n;
    n = 0;
    while (vec_n == base && n < 12) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(32'(vec_n - base), 32'h1, "vector taken");
    chk(32'(last_pc), 32'(`VECTOR_ADDR), "vector pc");
  endtask

  // Flags cleared first, otherwise the return re-enters at once
  task isr_end(input logic [31:0] ctl);
    int n, r0;
    wr(`IRQ_CTRL_OFS, ctl);
    r0 = ret_n;
    n  = 0;
    @(posedge core_clk_i) ret_req <= 1;
    @(posedge core_clk_i) ret_req <= 0;
    while (ret_n == r0 && n < 12) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(32'(last_pc), 32'(push_exp), "return pc");
  endtask

  task test_done;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1;
    rdc(`IRQ_CTRL_OFS, 32'(`CTL_RST), "ctrl reset");
    rdc(`IRQ_OPT_OFS, 32'(`OPT_RST), "option reset");
    rdc(`IRQ_PFLAG1_OFS, 32'(`PER_RST), "pflag reset");
    rdc(`IRQ_STAT_OFS, 32'(`STAT_RST), "status reset");
    rdc(`IRQ_MASK_OFS, 32'h0, "mask reset");
    rdc(8'h1c, 32'h0, "unmapped read");
    chk(32'(err), 32'h1, "unmapped error");
    wr(`IRQ_PEN1_OFS, 32'hff);
    rdc(`IRQ_PEN1_OFS, 32'hf, "four peripheral enables");
    pin_set(1);
    rdc(`IRQ_CTRL_OFS, 32'h02, "rising edge flag");
    chk(32'(irq_req), 32'h0, "pin disabled");
    wr(`IRQ_CTRL_OFS, 32'h0);
    pin_set(0);
    rdc(`IRQ_CTRL_OFS, 32'h0, "falling edge ignored");
    wr(`IRQ_OPT_OFS, 32'h0);
    pin_set(1);
    rdc(`IRQ_CTRL_OFS, 32'h0, "rising edge ignored");
    pin_set(0);
    rdc(`IRQ_CTRL_OFS, 32'h02, "falling edge flag");
    v0 = vec_n;
    wr(`IRQ_CTRL_OFS, 32'h92);
    wait_vec(v0);
    rdc(`IRQ_CTRL_OFS, 32'h12, "global enable cleared");
    isr_end(32'h10);
    rdc(`IRQ_CTRL_OFS, 32'h90, "global enable restored");
    pin_set(1);
    v0 = vec_n;
    pin_set(0);
    wait_vec(v0);
    chk(32'((vec_cyc - t0 - 1) inside {[3:4]}), 32'h1, "pin latency");
    isr_end(32'h10);
    wr(`IRQ_CTRL_OFS, 32'h20);
    @(posedge core_clk_i) tcnt <= 8'hfe;
    @(posedge core_clk_i) tcnt <= 8'hff;
    rdc(`IRQ_CTRL_OFS, 32'h20, "no overflow yet");
    tcnt <= 8'h00;
    rdc(`IRQ_CTRL_OFS, 32'h24, "overflow flag");
    chk(32'(irq_req), 32'h0, "global enable off");
    @(posedge core_clk_i) port <= 4'h8;
    repeat (5) @(posedge core_clk_i);
    rdc(`IRQ_CTRL_OFS, 32'h25, "port change flag");
    v0 = vec_n;
    wr(`IRQ_CTRL_OFS, 32'ha5);
    wait_vec(v0);
    isr_end(32'h20);
    @(posedge core_clk_i) pev <= 4'h4;
    @(posedge core_clk_i) pev <= 4'h0;
    rdc(`IRQ_PFLAG1_OFS, 32'h4, "peripheral flag");
    v0 = vec_n;
    wr(`IRQ_CTRL_OFS, 32'h80);
    repeat (6) @(posedge core_clk_i);
    chk(32'(vec_n - v0), 32'h0, "group enable off");
    wr(`IRQ_CTRL_OFS, 32'hc0);
    wait_vec(v0);
    wr(`IRQ_PFLAG1_OFS, 32'h0);
    isr_end(32'h40);
    wr(`IRQ_OPT_OFS, 32'h1);
    wr(`IRQ_CTRL_OFS, 32'h10);
    w0 = wake_n;
    v0 = vec_n;
    @(posedge core_clk_i) sleep <= 1;
    pin_set(1);
    chk(32'(wake_n > w0), 32'h1, "wake from sleep");
    chk(32'(vec_n - v0), 32'h0, "no vector while disabled");
    // Global enable set while asleep: vector only once the core runs again
    wr(`IRQ_CTRL_OFS, 32'h92);
    repeat (4) @(posedge core_clk_i);
    chk(32'(irq_req), 32'h1, "request held while asleep");
    chk(32'(vec_n - v0), 32'h0, "no vector while asleep");
    @(posedge core_clk_i) sleep <= 0;
    wait_vec(v0);
    isr_end(32'h10);
    wr(`IRQ_CTRL_OFS, 32'h0);
    chk(32'(irq), 32'h0, "irq masked");
    wr(`IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk(32'(irq), 32'h1, "irq unmasked");
    rdc(`IRQ_STAT_OFS, 32'h7, "sticky status");
    repeat (2) @(posedge core_clk_i);
    chk(32'(irq), 32'h0, "irq after clear");
    rdc(`IRQ_STAT_OFS, 32'h0, "status cleared");
    test_done;
  end
endmodule
